// [inc/ucc_pkg.sv]
package ucc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] UCC_FEATURE_ADDR = 8'h6a;
  localparam logic [7:0] UCC_POWER_ADDR = 8'h6b;
  localparam logic [7:0] UCC_STANDBY_ADDR = 8'h6c;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int UCC_FE_QUEUE_EN = 6;
  localparam int UCC_FE_AUX_EN = 5;
  localparam int UCC_FE_PORT_DIS = 4;
  localparam int UCC_FE_QUEUE_CLR = 2;
  localparam int UCC_FE_AUX_CLR = 1;
  localparam int UCC_FE_PATH_CLR = 0;
  localparam int UCC_PC_CHIP_CLR = 7;
  localparam int UCC_PC_SLEEP = 6;
  localparam int UCC_PC_CYCLE = 5;
  localparam int UCC_PC_THERM_OFF = 3;
  localparam int UCC_PC_TB_MSB = 2;
  localparam int UCC_PC_TB_LSB = 0;
  localparam int UCC_SW_RATE_MSB = 7;
  localparam int UCC_SW_RATE_LSB = 6;
  localparam int UCC_SW_RATE_X = 2;  // gyro x standby; y and z sit below it

  // ---------------------------------------------------------------
  // reset values and storage masks
  // ---------------------------------------------------------------
  localparam logic [7:0] UCC_FEATURE_RST = 8'h00;
  localparam logic [7:0] UCC_POWER_RST = 8'h00;
  localparam logic [7:0] UCC_STANDBY_RST = 8'h00;
  localparam logic [7:0] UCC_FEATURE_KEEP = 8'h70;
  localparam logic [7:0] UCC_POWER_KEEP = 8'h6f;
  localparam logic [7:0] UCC_STANDBY_KEEP = 8'hff;

  // ---------------------------------------------------------------
  // clock source codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    UCC_TB_INTERNAL = 3'h0,
    UCC_TB_RATE_X = 3'h1,
    UCC_TB_RATE_Y = 3'h2,
    UCC_TB_RATE_Z = 3'h3,
    UCC_TB_EXT_SLOW = 3'h4,
    UCC_TB_EXT_FAST = 3'h5,
    UCC_TB_RESERVED = 3'h6,
    UCC_TB_STOP = 3'h7
  } ucc_timebase_t;

  // ---------------------------------------------------------------
  // cycle mode states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    UCC_CY_IDLE = 3'b001,
    UCC_CY_DOZE = 3'b010,
    UCC_CY_WAKE = 3'b100
  } ucc_cycle_state_t;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned UCC_CLOCK_HZ = 100_000_000;
  // wake rates in hundredths of a hertz
  localparam int unsigned UCC_WAKE_CHZ_0 = 125;
  localparam int unsigned UCC_WAKE_CHZ_1 = 500;
  localparam int unsigned UCC_WAKE_CHZ_2 = 2000;
  localparam int unsigned UCC_WAKE_CHZ_3 = 4000;
  localparam int unsigned UCC_WAKE_CYCLES_0 = (UCC_CLOCK_HZ / UCC_WAKE_CHZ_0) * 100;
  localparam int unsigned UCC_WAKE_CYCLES_1 = (UCC_CLOCK_HZ / UCC_WAKE_CHZ_1) * 100;
  localparam int unsigned UCC_WAKE_CYCLES_2 = (UCC_CLOCK_HZ / UCC_WAKE_CHZ_2) * 100;
  localparam int unsigned UCC_WAKE_CYCLES_3 = (UCC_CLOCK_HZ / UCC_WAKE_CHZ_3) * 100;
  localparam int unsigned UCC_CLEAR_CYCLES = 4;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ucc_reg_req_t;

  typedef struct packed {
    logic sleep_state;
    logic thermal_off;
    logic timing_gen_reset;
    logic [2:0] timebase;
  } ucc_power_t;

endpackage

// [hw/ucc_clear_pulse.sv]
module ucc_clear_pulse #(
  parameter int unsigned CYCLES = 4
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_start,
  output logic o_busy,
  output logic o_done
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] count_r;

  // holds busy for CYCLES clocks after a start, then one done pulse
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_r <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!o_busy && i_start) begin
        o_busy <= 1'b1;
        count_r <= W'(CYCLES - 1);
      end else if (o_busy) begin
        if (count_r == '0) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          count_r <= count_r - W'(1);
        end
      end
    end
  end

endmodule

// [hw/ucc_power_clock_ctrl.sv]
module ucc_power_clock_ctrl #(
  parameter bit SPI_CAPABLE = 1'b1,
  parameter int unsigned CLEAR_CYCLES = ucc_pkg::UCC_CLEAR_CYCLES,
  parameter int unsigned WAKE_CYCLES_0 = ucc_pkg::UCC_WAKE_CYCLES_0,
  parameter int unsigned WAKE_CYCLES_1 = ucc_pkg::UCC_WAKE_CYCLES_1,
  parameter int unsigned WAKE_CYCLES_2 = ucc_pkg::UCC_WAKE_CYCLES_2,
  parameter int unsigned WAKE_CYCLES_3 = ucc_pkg::UCC_WAKE_CYCLES_3
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire ucc_pkg::ucc_reg_req_t i_reg,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic i_primary_sda,
  input wire logic i_primary_scl,
  input wire logic i_aux_master_sda_oe,
  input wire logic i_aux_master_scl_oe,
  output logic o_aux_serial_data_o,
  output logic o_aux_serial_data_oe,
  output logic o_aux_serial_clock_o,
  output logic o_aux_serial_clock_oe,
  output logic o_aux_master_active,
  output logic o_primary_i2c_enable,
  output logic o_spi_enable,
  output logic o_sample_queue_allow,
  output logic o_sample_queue_clear,
  output logic o_aux_master_clear,
  output logic o_sensor_path_clear,
  output logic o_whole_chip_clear,
  output ucc_pkg::ucc_power_t o_power,
  output logic [5:0] o_axis_standby,
  output logic o_cycle_sample,
  output logic o_gyro_off_ok
);
  import ucc_pkg::*;

  // ---------------------------------------------------------------
  // storage and decode
  // ---------------------------------------------------------------
  logic [7:0] feature_r, power_r, standby_r, feature_nxt, standby_nxt;
  logic wr_feature, wr_power, wr_standby;
  logic queue_clr_busy, aux_clr_busy, chip_clr_busy, chip_clr_done;
  logic [2:0] tb_nxt, rate_stby, eff_tb;
  ucc_cycle_state_t cycle_r;
  logic [31:0] wake_cnt_r, wake_load;
  // chip clear in progress freezes host writes
  always_comb begin
    wr_feature = 1'b0;
    wr_power = 1'b0;
    wr_standby = 1'b0;
    if (i_reg.wr && !chip_clr_busy) begin
      if (i_reg.addr == UCC_FEATURE_ADDR) begin
        wr_feature = 1'b1;
      end else if (i_reg.addr == UCC_POWER_ADDR) begin
        wr_power = 1'b1;
      end else if (i_reg.addr == UCC_STANDBY_ADDR) begin
        wr_standby = 1'b1;
      end
    end
  end

  // next values of stored fields; reserved and self-clearing bits dropped
  always_comb begin
    feature_nxt = i_reg.wdata & UCC_FEATURE_KEEP;
    if (!SPI_CAPABLE) begin
      feature_nxt[UCC_FE_PORT_DIS] = 1'b0;
    end
    standby_nxt = wr_standby ? (i_reg.wdata & UCC_STANDBY_KEEP) : standby_r;
    rate_stby = standby_nxt[UCC_SW_RATE_X:0];
    tb_nxt = wr_power ? i_reg.wdata[UCC_PC_TB_MSB:UCC_PC_TB_LSB]
                      : power_r[UCC_PC_TB_MSB:UCC_PC_TB_LSB];
    if ((tb_nxt == UCC_TB_RATE_X && rate_stby[2]) ||
        (tb_nxt == UCC_TB_RATE_Y && rate_stby[1]) ||
        (tb_nxt == UCC_TB_RATE_Z && rate_stby[0])) begin
      tb_nxt = UCC_TB_INTERNAL;
    end
  end

  // ---------------------------------------------------------------
  // self-clearing resets
  // ---------------------------------------------------------------
  // start the clears
  ucc_clear_pulse #(.CYCLES(CLEAR_CYCLES)) u_queue_clr (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .o_busy(queue_clr_busy), .o_done(),
    .i_start(wr_feature && i_reg.wdata[UCC_FE_QUEUE_CLR] && !feature_r[UCC_FE_QUEUE_EN]));
  ucc_clear_pulse #(.CYCLES(CLEAR_CYCLES)) u_aux_clr (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .o_busy(aux_clr_busy), .o_done(),
    .i_start(wr_feature && i_reg.wdata[UCC_FE_AUX_CLR] && !feature_r[UCC_FE_AUX_EN]));
  ucc_clear_pulse #(.CYCLES(CLEAR_CYCLES)) u_path_clr (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .o_busy(o_sensor_path_clear), .o_done(),
    .i_start(wr_feature && i_reg.wdata[UCC_FE_PATH_CLR]));
  ucc_clear_pulse #(.CYCLES(CLEAR_CYCLES)) u_chip_clr (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .o_busy(chip_clr_busy), .o_done(chip_clr_done),
    .i_start(wr_power && i_reg.wdata[UCC_PC_CHIP_CLR]));

  // queue emptied only by its own clear
  assign o_sample_queue_clear = queue_clr_busy;
  assign o_aux_master_clear = aux_clr_busy;
  assign o_whole_chip_clear = chip_clr_busy;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // internal timebase at reset
  // defaults restored when chip clear ends
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      feature_r <= UCC_FEATURE_RST;
      power_r <= UCC_POWER_RST;
      standby_r <= UCC_STANDBY_RST;
    end else if (chip_clr_done) begin
      feature_r <= UCC_FEATURE_RST;
      power_r <= UCC_POWER_RST;
      standby_r <= UCC_STANDBY_RST;
    end else begin
      if (wr_feature) begin
        feature_r <= feature_nxt;
      end
      standby_r <= standby_nxt;
      if (wr_power) begin
        power_r <= i_reg.wdata & UCC_POWER_KEEP;
      end
      power_r[UCC_PC_TB_MSB:UCC_PC_TB_LSB] <= tb_nxt;
    end
  end
  assign o_sample_queue_allow = feature_r[UCC_FE_QUEUE_EN];
  assign o_axis_standby = standby_r[5:0];

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // reserved bits zero
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg.rd;
      if (!i_reg.rd) begin
        o_reg_rdata <= 8'h00;
      end else if (i_reg.addr == UCC_FEATURE_ADDR) begin
        o_reg_rdata <= feature_r | {5'h00, queue_clr_busy, aux_clr_busy, o_sensor_path_clear};
      end else if (i_reg.addr == UCC_POWER_ADDR) begin
        o_reg_rdata <= power_r | {chip_clr_busy, 7'h00};
      end else if (i_reg.addr == UCC_STANDBY_ADDR) begin
        o_reg_rdata <= standby_r;
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // serial port routing
  // ---------------------------------------------------------------
  // open-drain lines: value held low, enable pulls the wire
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_aux_serial_data_o <= 1'b0;
      o_aux_serial_clock_o <= 1'b0;
      o_aux_serial_data_oe <= 1'b0;
      o_aux_serial_clock_oe <= 1'b0;
      o_aux_master_active <= 1'b0;
      o_primary_i2c_enable <= 1'b1;
      o_spi_enable <= 1'b0;
    end else begin
      o_aux_serial_data_o <= 1'b0;
      o_aux_serial_clock_o <= 1'b0;
      o_aux_master_active <= feature_r[UCC_FE_AUX_EN];
      if (feature_r[UCC_FE_AUX_EN]) begin
        o_aux_serial_data_oe <= i_aux_master_sda_oe;
        o_aux_serial_clock_oe <= i_aux_master_scl_oe;
      end else begin
        o_aux_serial_data_oe <= !i_primary_sda;
        o_aux_serial_clock_oe <= !i_primary_scl;
      end
      o_primary_i2c_enable <= !feature_r[UCC_FE_PORT_DIS];
      o_spi_enable <= feature_r[UCC_FE_PORT_DIS];
    end
  end

  // ---------------------------------------------------------------
  // cycle mode wake timer
  // ---------------------------------------------------------------
  // wake period select
  // the wake cycle and the reload cycle both belong to the period
  always_comb begin
    case (standby_r[UCC_SW_RATE_MSB:UCC_SW_RATE_LSB])
      2'h0: wake_load = WAKE_CYCLES_0 - 2;
      2'h1: wake_load = WAKE_CYCLES_1 - 2;
      2'h2: wake_load = WAKE_CYCLES_2 - 2;
      default: wake_load = WAKE_CYCLES_3 - 2;
    endcase
  end
  // doze then wake for one sample
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cycle_r <= UCC_CY_IDLE;
      wake_cnt_r <= 32'h0;
      o_cycle_sample <= 1'b0;
    end else begin
      o_cycle_sample <= 1'b0;
      if (!power_r[UCC_PC_CYCLE] || power_r[UCC_PC_SLEEP]) begin
        cycle_r <= UCC_CY_IDLE;
      end else begin
        case (cycle_r)
          UCC_CY_IDLE: begin
            cycle_r <= UCC_CY_DOZE;
            wake_cnt_r <= wake_load;
          end
          UCC_CY_DOZE: begin
            if (wake_cnt_r == 32'h0) begin
              cycle_r <= UCC_CY_WAKE;
              o_cycle_sample <= 1'b1;
            end else begin
              wake_cnt_r <= wake_cnt_r - 32'h1;
            end
          end
          UCC_CY_WAKE: begin
            cycle_r <= UCC_CY_DOZE;
            wake_cnt_r <= wake_load;
          end
          default: cycle_r <= UCC_CY_IDLE;
        endcase
      end
    end
  end
  // ---------------------------------------------------------------
  // power and timebase outputs
  // ---------------------------------------------------------------
  // timebase codes
  always_comb begin
    eff_tb = power_r[UCC_PC_TB_MSB:UCC_PC_TB_LSB];
    if (eff_tb == UCC_TB_RESERVED || eff_tb == UCC_TB_STOP) begin
      eff_tb = UCC_TB_INTERNAL;
    end
  end
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_power <= '0;
      o_gyro_off_ok <= 1'b1;
    end else begin
      o_power.sleep_state <= power_r[UCC_PC_SLEEP] ||
                             (power_r[UCC_PC_CYCLE] && cycle_r != UCC_CY_WAKE);
      o_power.thermal_off <= power_r[UCC_PC_THERM_OFF];
      o_power.timing_gen_reset <= power_r[UCC_PC_TB_MSB:UCC_PC_TB_LSB] == UCC_TB_STOP;
      o_power.timebase <= eff_tb;
      o_gyro_off_ok <= eff_tb == UCC_TB_INTERNAL || eff_tb == UCC_TB_EXT_SLOW ||
                       eff_tb == UCC_TB_EXT_FAST;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  sequence s_clear_hold;
    o_sensor_path_clear [*4] ##1 !o_sensor_path_clear;
  endsequence
  a_path_clear_len: assert property ($rose(o_sensor_path_clear) |-> s_clear_hold)
    else $error("path clear pulse length wrong");
  a_queue_clear_gate: assert property ($rose(o_sample_queue_clear) |->
      !$past(feature_r[UCC_FE_QUEUE_EN])) else $error("queue clear while queue enabled");
  a_aux_clear_gate: assert property ($rose(o_aux_master_clear) |->
      !$past(feature_r[UCC_FE_AUX_EN])) else $error("aux clear while master enabled");
  a_bypass_follow: assert property (!feature_r[UCC_FE_AUX_EN] ##1
      !feature_r[UCC_FE_AUX_EN] |-> o_aux_serial_data_oe == !$past(i_primary_sda))
    else $error("aux data not following primary");
  a_master_drive: assert property (feature_r[UCC_FE_AUX_EN] |=>
      o_aux_master_active && o_aux_serial_clock_oe == $past(i_aux_master_scl_oe))
    else $error("aux master not driving clock");
  a_spi_select: assert property (feature_r[UCC_FE_PORT_DIS] |=>
      o_spi_enable && !o_primary_i2c_enable) else $error("spi not selected");
  a_queue_allow: assert property (wr_feature && !chip_clr_done |=>
      o_sample_queue_allow == $past(i_reg.wdata[UCC_FE_QUEUE_EN]))
    else $error("queue allow not following write");
  a_timebase_stop: assert property (power_r[UCC_PC_TB_MSB:UCC_PC_TB_LSB] == UCC_TB_STOP
      |=> o_power.timing_gen_reset) else $error("stop code without timing reset");
  a_axis_fallback: assert property (wr_standby && i_reg.wdata[UCC_SW_RATE_X] &&
      power_r[UCC_PC_TB_MSB:UCC_PC_TB_LSB] == UCC_TB_RATE_X |=>
      power_r[UCC_PC_TB_MSB:UCC_PC_TB_LSB] == UCC_TB_INTERNAL)
    else $error("no fallback to internal timebase");
  a_chip_defaults: assert property (chip_clr_done |=> power_r == UCC_POWER_RST &&
      feature_r == UCC_FEATURE_RST && standby_r == UCC_STANDBY_RST)
    else $error("registers not at defaults after chip clear");
  a_wake_sample: assert property (o_cycle_sample |-> $past(power_r[UCC_PC_CYCLE]) &&
      !$past(power_r[UCC_PC_SLEEP]) ##1 !o_cycle_sample)
    else $error("wake sample outside cycle mode");
  a_sleep_out: assert property (power_r[UCC_PC_SLEEP] |=> o_power.sleep_state)
    else $error("sleep bit not reflected");
endmodule

// [sim/ucc_host_model.sv]
// host on the primary port, issuing single-byte register accesses
module ucc_host_model
  import ucc_pkg::*;
#(
  parameter bit I2C_ONLY = 1'b0
) (
  input wire logic i_clock,
  output ucc_pkg::ucc_reg_req_t o_reg,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial o_reg = '0;

  // one write; the strobe rests a cycle first so it is never re-raised in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    #1;
    o_reg.addr = a;
    o_reg.wdata = d;
    if (I2C_ONLY && a == UCC_FEATURE_ADDR) o_reg.wdata[UCC_FE_PORT_DIS] = 1'b0;
    o_reg.wr = 1'b1;
    @(posedge i_clock);
    #1;
    o_reg.wr = 1'b0;
    o_reg.addr = ~a;
    o_reg.wdata = ~d;
  endtask

  // one read; data taken in the cycle after the edge that takes the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    #1;
    o_reg.addr = a;
    o_reg.rd = 1'b1;
    @(posedge i_clock);
    #1;
    o_reg.rd = 1'b0;
    o_reg.addr = ~a;
    d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
  endtask
endmodule

// [sim/user_power_clock_control_test.sv]
module user_power_clock_control_test;
  import ucc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  ucc_reg_req_t reg_req;
  logic [7:0] rdata;
  logic rvalid;
  logic sda = 1'b0;
  logic scl = 1'b0;
  logic m_sda = 1'b0;
  logic m_scl = 1'b0;
  logic oe_d, oe_c, act, i2c_en, spi_en, q_allow, q_clr, a_clr, p_clr, c_clr, cyc, gok;
  logic od_d, od_c;
  ucc_power_t pw;
  logic [5:0] stby;
  logic [7:0] d;
  logic [7:0] v;
  int fails = 0;
  int checks_done = 0;
  int seed = 32'h8184505e;
  int n;
  int g;
  int w[4] = '{20, 10, 6, 4};

  // 100 MHz clock
  always #5 i_clock = ~i_clock;

  ucc_power_clock_ctrl #(.CLEAR_CYCLES(4), .WAKE_CYCLES_0(20), .WAKE_CYCLES_1(10),
    .WAKE_CYCLES_2(6), .WAKE_CYCLES_3(4)) u_ucc_power_clock_ctrl (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_reg(reg_req), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_primary_sda(sda), .i_primary_scl(scl),
    .i_aux_master_sda_oe(m_sda), .i_aux_master_scl_oe(m_scl), .o_aux_serial_data_o(od_d),
    .o_aux_serial_data_oe(oe_d), .o_aux_serial_clock_o(od_c), .o_aux_serial_clock_oe(oe_c),
    .o_aux_master_active(act), .o_primary_i2c_enable(i2c_en), .o_spi_enable(spi_en),
    .o_sample_queue_allow(q_allow), .o_sample_queue_clear(q_clr),
    .o_aux_master_clear(a_clr), .o_sensor_path_clear(p_clr), .o_whole_chip_clear(c_clr),
    .o_power(pw), .o_axis_standby(stby), .o_cycle_sample(cyc), .o_gyro_off_ok(gok));

  ucc_host_model u_ucc_host_model (.i_clock(i_clock), .o_reg(reg_req), .i_rdata(rdata),
    .i_rvalid(rvalid));

  // effective timebase: reserved and stop codes run from the internal source
  function automatic logic [2:0] eff_tb(input int c);
    return (c >= 6) ? 3'h0 : c[2:0];
  endfunction

  // pick one of the clear strobes
  function automatic logic clr_sel(input int k);
    case (k)
      0: return q_clr;
      1: return a_clr;
      default: return p_clr;
    endcase
  endfunction

  task automatic step();
    @(posedge i_clock);
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] got);
    checks_done++;
    if (got !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", s, e, got);
      fails++;
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    u_ucc_host_model.rd(a, d);
    chk($sformatf("register %h", a), e, d);
  endtask

  // length of a clear strobe counted from the cycle after the write
  task automatic pulse(input int k, input int e);
    n = 0;
    while (clr_sel(k) === 1'b1 && n < 10) begin
      n++;
      step();
    end
    chk("clear strobe length", 8'(e), 8'(n));
  endtask

  // bounded wait for the next cycle-mode sample
  task automatic waitp(output int c);
    c = 0;
    while (cyc !== 1'b1) begin
      c++;
      step();
      if (c > 100) begin
        fails++;
        report_and_stop();
      end
    end
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge i_clock);
    #1;
    i_reset_n = 1'b1;
    chk("i2c enable", 8'h01, 8'(i2c_en));
    chk("gyro off ok", 8'h01, 8'(gok));
    rdchk(UCC_FEATURE_ADDR, 8'h00);
    rdchk(UCC_POWER_ADDR, 8'h00);
    rdchk(8'h6d, 8'h00);
    u_ucc_host_model.wr(UCC_FEATURE_ADDR, 8'h88);
    rdchk(UCC_FEATURE_ADDR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      sda = 1'($random(seed));
      scl = 1'($random(seed));
      u_ucc_host_model.wr(UCC_STANDBY_ADDR, v);
      chk("standby pins", 8'(v[5:0]), 8'(stby));
      chk("bypass data", 8'(!sda), 8'(oe_d));
      chk("bypass clock", 8'(!scl), 8'(oe_c));
      rdchk(UCC_STANDBY_ADDR, v);
    end
    u_ucc_host_model.wr(UCC_STANDBY_ADDR, 8'h00);
    for (int c = 0; c < 8; c++) begin
      u_ucc_host_model.wr(UCC_POWER_ADDR, 8'(c));
      step();
      chk("timebase", 8'(eff_tb(c)), 8'(pw.timebase));
      chk("timing reset", 8'(c == 7), 8'(pw.timing_gen_reset));
      chk("gyro off ok", 8'(eff_tb(c) == 3'h0 || c == 4 || c == 5), 8'(gok));
      rdchk(UCC_POWER_ADDR, 8'(c));
    end
    u_ucc_host_model.wr(UCC_POWER_ADDR, 8'h01);
    u_ucc_host_model.wr(UCC_STANDBY_ADDR, 8'h04);
    rdchk(UCC_POWER_ADDR, 8'h00);
    u_ucc_host_model.wr(UCC_POWER_ADDR, 8'h58);
    step();
    chk("sleep", 8'h01, 8'(pw.sleep_state));
    chk("thermal off", 8'h01, 8'(pw.thermal_off));
    rdchk(UCC_POWER_ADDR, 8'h48);
    u_ucc_host_model.wr(UCC_FEATURE_ADDR, 8'h40);
    chk("queue allow", 8'h01, 8'(q_allow));
    u_ucc_host_model.wr(UCC_FEATURE_ADDR, 8'h44);
    pulse(0, 0);
    u_ucc_host_model.wr(UCC_FEATURE_ADDR, 8'h00);
    chk("queue allow", 8'h00, 8'(q_allow));
    u_ucc_host_model.wr(UCC_FEATURE_ADDR, 8'h04);
    pulse(0, 4);
    rdchk(UCC_FEATURE_ADDR, 8'h00);
    u_ucc_host_model.wr(UCC_FEATURE_ADDR, 8'h20);
    u_ucc_host_model.wr(UCC_FEATURE_ADDR, 8'h22);
    pulse(1, 0);
    chk("master active", 8'h01, 8'(act));
    m_sda = 1'($random(seed));
    m_scl = ~m_sda;
    step();
    step();
    chk("master data", 8'(m_sda), 8'(oe_d));
    chk("master clock", 8'(m_scl), 8'(oe_c));
    chk("aux line values", 8'h00, {6'h00, od_d, od_c});
    u_ucc_host_model.wr(UCC_FEATURE_ADDR, 8'h00);
    u_ucc_host_model.wr(UCC_FEATURE_ADDR, 8'h02);
    pulse(1, 4);
    u_ucc_host_model.wr(UCC_FEATURE_ADDR, 8'h01);
    pulse(2, 4);
    u_ucc_host_model.wr(UCC_FEATURE_ADDR, 8'h10);
    step();
    chk("spi enable", 8'h01, 8'(spi_en));
    chk("i2c enable", 8'h00, 8'(i2c_en));
    u_ucc_host_model.wr(UCC_FEATURE_ADDR, 8'h00);
    for (int r = 0; r < 4; r++) begin
      u_ucc_host_model.wr(UCC_STANDBY_ADDR, {2'(r), 6'h00});
      u_ucc_host_model.wr(UCC_POWER_ADDR, 8'h20);
      waitp(n);
      step();
      waitp(g);
      chk("wake gap", 8'(w[r]), 8'(g + 1));
    end
    u_ucc_host_model.wr(UCC_POWER_ADDR, 8'h60);
    step();
    g = 0;
    repeat (40) begin
      step();
      if (cyc === 1'b1) g++;
    end
    chk("samples while asleep", 8'h00, 8'(g));
    chk("sleep", 8'h01, 8'(pw.sleep_state));
    u_ucc_host_model.wr(UCC_STANDBY_ADDR, 8'hff);
    u_ucc_host_model.wr(UCC_POWER_ADDR, 8'h80);
    chk("chip clear", 8'h01, 8'(c_clr));
    n = 0;
    while (c_clr === 1'b1 && n < 10) begin
      n++;
      step();
    end
    chk("chip clear length", 8'h04, 8'(n));
    rdchk(UCC_STANDBY_ADDR, 8'h00);
    rdchk(UCC_POWER_ADDR, 8'h00);
    u_ucc_host_model.wr(UCC_FEATURE_ADDR, 8'h01);
    pulse(2, 4);
    report_and_stop();
  end
endmodule
